// ==== src/lsr_defs.vh ====
`ifndef LSR_DEFS_VH
`define LSR_DEFS_VH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSR_RST_PATTERN 16'hFFFF
`define LSR_RST_FACTOR  9'h001
`define LSR_RST_WIDTH   4'h1

// ----------------------------------------------------------------
// Limits and fixed point
// ----------------------------------------------------------------
`define LSR_FACTOR_MIN  9'h001
`define LSR_FACTOR_MAX  9'h100
`define LSR_MAX_WIDTH   4'h8
`define LSR_WIDTH_BIAS  9'h008
`define LSR_CENTER      4'h8
`define LSR_T_ONE       16'hFFFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LSR_DIV_STEPS   5'h10

// ----------------------------------------------------------------
// Varying interpolation modes
// ----------------------------------------------------------------
`define LSR_VAR_SMOOTH  2'h0
`define LSR_VAR_NOPERSP 2'h1
`define LSR_VAR_FLAT    2'h2

`endif

// ==== src/lsr_line_raster.v ====
// Operation
// R1: Slope within minus one to one is x-major, otherwise y-major.
// R2: Emit fragments whose diamond the segment crosses, not the end one.
// R3: Boundary endpoints behave as if nudged slightly toward minus x, y.
// R4: The end fragment is never emitted; shared joints appear once.
// R5: Stepped fragments lie within one unit of the diamond choice.
// R6: Fragment count differs from the diamond count by at most one.
// R7: One fragment per column for x-major, per row for y-major.
// R8: Joined segments of same axis and direction: no duplicate, no gap.
// R9: Parameter t is projection of center onto segment over length squared.
// R10: Color and similar data interpolate perspective-correctly by clip w.
// R11: Depth interpolates linearly in t.
// R12: Noperspective varyings interpolate like depth; unqualified ones do not.
// R13: Flat varyings take the provoking vertex value.
// R14: Pattern keeps low 16 bits; repeat factor clamps to 1..256.
// R15: With dashing off the pattern acts as all ones.
// R16: Emit only if pattern bit floor(count/factor) mod 16 is set.
// R17: Counter starts at zero, steps once per fragment from start to end.
// R18: Counter clears at group start and before each independent pair.
// R19: Clipped segments may start with any counter value.
// R20: Width rounds to nearest, clamps to maximum, zero acts as one.
// R21: Wide lines shift down by (w-1)/2 and emit w-fragment minor runs.
// R22: Wide lines take one dash decision per major position.
// R23: Reset gives all-ones pattern, factor one, dash off, width one, aa off.
// R24: Fragments leave on valid/ready, held stable, stalling while not ready.
`timescale 1ns/10ps
`include "lsr_defs.vh"

module lsr_line_raster (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        set_dash_pattern,
    input  wire [15:0] dash_factor_in,
    input  wire [31:0] dash_pattern_in,
    input  wire        cfg_wr,
    input  wire        cfg_dash_en,
    input  wire        cfg_aa_en,
    input  wire [7:0]  cfg_width,
    output wire        aa_en,
    output wire [3:0]  line_width,
    input  wire        seg_valid,
    output wire        seg_ready,
    input  wire [15:0] seg_xa,
    input  wire [15:0] seg_ya,
    input  wire [15:0] seg_xb,
    input  wire [15:0] seg_yb,
    input  wire [15:0] seg_za,
    input  wire [15:0] seg_zb,
    input  wire [15:0] seg_ca,
    input  wire [15:0] seg_cb,
    input  wire [15:0] seg_iwa,
    input  wire [15:0] seg_iwb,
    input  wire [15:0] seg_va,
    input  wire [15:0] seg_vb,
    input  wire [15:0] seg_vprov,
    input  wire [1:0]  seg_vmode,
    input  wire        seg_group_start,
    input  wire        seg_independent,
    output wire        frag_valid,
    input  wire        frag_ready,
    output wire [11:0] frag_x,
    output wire [11:0] frag_y,
    output wire [15:0] frag_t,
    output wire [15:0] frag_z,
    output wire [15:0] frag_c,
    output wire [15:0] frag_v
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam [2:0] ST_IDLE  = 3'h0;
localparam [2:0] ST_POS   = 3'h1;
localparam [2:0] ST_DLOAD = 3'h2;
localparam [2:0] ST_DIV   = 3'h3;
localparam [2:0] ST_EMIT  = 3'h4;
localparam [2:0] ST_STEP  = 3'h5;

localparam [1:0] SEL_T = 2'h0;
localparam [1:0] SEL_C = 2'h1;
localparam [1:0] SEL_V = 2'h2;

// Pixel index of a 12.4 coordinate, nudged just below exact edges
function [11:0] lsr_pix;
    input [15:0] v;
    reg   [15:0] tmp;
    begin
        tmp = v - 16'h0001;
        lsr_pix = (v == 16'h0000) ? 12'h000 : tmp[15:4];
    end
endfunction

// ----------------------------------------------------------------
// Line state
// ----------------------------------------------------------------
reg  [15:0] pattern_ff;
reg  [8:0]  factor_ff;
reg         dash_en_ff;
reg         aa_ff;
reg  [3:0]  width_ff;
reg  [2:0]  state_ff;
reg  [15:0] xa_ff, ya_ff, za_ff, zb_ff, ca_ff, cb_ff;
reg  [15:0] iwa_ff, iwb_ff, va_ff, vb_ff, vprov_ff;
reg  [1:0]  vmode_ff;
reg  signed [16:0] dx_ff, dy_ff;
reg         xmaj_ff, sm_neg_ff, sn_neg_ff;
reg  [11:0] m_ff, n_ff, left_ff, dn_ff, dm_ff;
reg  signed [14:0] err_ff;
reg  [3:0]  bidx_ff;
reg  [8:0]  rep_ff;
reg  [1:0]  sel_ff;
reg  [51:0] rem_ff, dsh_ff;
reg  [15:0] q_ff;
reg  [4:0]  cnt_ff;
reg  [3:0]  run_ff;
reg  [11:0] fx_ff, fy_ff;
reg  [15:0] ft_ff, fz_ff, fc_ff, fv_ff;

// ----------------------------------------------------------------
// Configuration
// ----------------------------------------------------------------
wire [8:0] wsum = {1'b0, cfg_width} + `LSR_WIDTH_BIAS;
wire [4:0] wrnd = wsum[8:4];
wire [3:0] nxt_width = (wrnd == 5'h00) ? 4'h1 :                   // [R20]
                       (wrnd > {1'b0, `LSR_MAX_WIDTH}) ?
                       `LSR_MAX_WIDTH : wrnd[3:0];
wire [8:0] nxt_factor = (dash_factor_in[15] ||
                         dash_factor_in == 16'h0000) ? `LSR_FACTOR_MIN :
                        (dash_factor_in > {7'h00, `LSR_FACTOR_MAX}) ?
                        `LSR_FACTOR_MAX : dash_factor_in[8:0];   // [R14]

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        pattern_ff <= `LSR_RST_PATTERN;                           // [R23]
        factor_ff  <= `LSR_RST_FACTOR;
        dash_en_ff <= 1'b0;
        aa_ff      <= 1'b0;
        width_ff   <= `LSR_RST_WIDTH;
    end else begin
        if (set_dash_pattern) begin
            pattern_ff <= dash_pattern_in[15:0];                  // [R14]
            factor_ff  <= nxt_factor;
        end
        if (cfg_wr) begin
            dash_en_ff <= cfg_dash_en;
            aa_ff      <= cfg_aa_en;
            width_ff   <= nxt_width;
        end
    end
end

// ----------------------------------------------------------------
// Segment setup
// ----------------------------------------------------------------
wire signed [16:0] sdx = $signed({1'b0, seg_xb}) - $signed({1'b0, seg_xa});
wire signed [16:0] sdy = $signed({1'b0, seg_yb}) - $signed({1'b0, seg_ya});
wire [16:0] adx = sdx[16] ? (17'h00000 - sdx) : sdx;
wire [16:0] ady = sdy[16] ? (17'h00000 - sdy) : sdy;
wire        sxmaj = (ady <= adx);                                 // [R1]
wire [11:0] pxa = lsr_pix(seg_xa);                                // [R3]
wire [11:0] pya = lsr_pix(seg_ya);
wire [11:0] pxb = lsr_pix(seg_xb);
wire [11:0] pyb = lsr_pix(seg_yb);
wire [11:0] ms = sxmaj ? pxa : pya;
wire [11:0] me = sxmaj ? pxb : pyb;
wire [11:0] ns = sxmaj ? pya : pxa;
wire [11:0] ne = sxmaj ? pyb : pxb;
wire        smn = (me < ms);
wire        snn = (ne < ns);
wire [11:0] sdm = smn ? (ms - me) : (me - ms);
wire [11:0] sdn = snn ? (ns - ne) : (ne - ns);
wire signed [14:0] serr = $signed({2'b00, sdn, 1'b0}) -
                          $signed({3'b000, sdm});

// ----------------------------------------------------------------
// Interpolation arithmetic
// ----------------------------------------------------------------
wire [11:0] bx = xmaj_ff ? m_ff : n_ff;
wire [11:0] by = xmaj_ff ? n_ff : m_ff;
wire signed [17:0] relx = $signed({2'b00, bx, `LSR_CENTER}) -
                          $signed({2'b00, xa_ff});
wire signed [17:0] rely = $signed({2'b00, by, `LSR_CENTER}) -
                          $signed({2'b00, ya_ff});
wire signed [36:0] tnum = relx * dx_ff + rely * dy_ff;            // [R9]
wire signed [36:0] tden = dx_ff * dx_ff + dy_ff * dy_ff;
wire [51:0] tden_u = {15'h0000, tden};
wire [51:0] tn_load = tnum[36] ? 52'h0 :
                      (tnum >= tden) ? ((tden_u << 16) - 52'h1) :
                      ({15'h0000, tnum} << 16);
wire [15:0] omt = `LSR_T_ONE - ft_ff;
wire [31:0] cwa = ca_ff * iwa_ff;
wire [31:0] cwb = cb_ff * iwb_ff;
wire [31:0] vwa = va_ff * iwa_ff;
wire [31:0] vwb = vb_ff * iwb_ff;
wire [51:0] cnum = omt * cwa + ft_ff * cwb;                       // [R10]
wire [51:0] vnum = omt * vwa + ft_ff * vwb;                       // [R12]
wire [51:0] pden = omt * iwa_ff + ft_ff * iwb_ff;
wire [51:0] ld_n = (sel_ff == SEL_T) ? tn_load :
                   (sel_ff == SEL_C) ? cnum : vnum;
wire [51:0] ld_d = (sel_ff == SEL_T) ? tden_u : pden;
wire [31:0] zlin = za_ff * omt + zb_ff * ft_ff;                   // [R11]
wire [31:0] vlin = va_ff * omt + vb_ff * ft_ff;                   // [R12]
wire [15:0] vsel = (vmode_ff == `LSR_VAR_FLAT) ? vprov_ff :       // [R13]
                   (vmode_ff == `LSR_VAR_NOPERSP) ? vlin[31:16] : fv_ff;
wire        rem_ge = (rem_ff >= dsh_ff);
wire [15:0] nxt_q = {q_ff[14:0], rem_ge};

// ----------------------------------------------------------------
// Dash and width
// ----------------------------------------------------------------
wire        dash_on = !dash_en_ff || pattern_ff[bidx_ff];          // [R15]
wire [3:0]  whalf = (width_ff - 4'h1) >> 1;
wire [11:0] nlow = n_ff - {8'h00, whalf};                         // [R21]
wire        run_last = (run_ff == width_ff - 4'h1);
wire        accept = (state_ff == ST_IDLE) && seg_valid;
wire signed [14:0] nxt_err = (err_ff > 0) ?
    err_ff + $signed({2'b00, dn_ff, 1'b0}) - $signed({2'b00, dm_ff, 1'b0}) :
    err_ff + $signed({2'b00, dn_ff, 1'b0});

// ----------------------------------------------------------------
// Stepping engine
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        state_ff <= ST_IDLE;
        {xa_ff, ya_ff, za_ff, zb_ff, ca_ff, cb_ff} <= 96'h0;
        {iwa_ff, iwb_ff, va_ff, vb_ff, vprov_ff} <= 80'h0;
        vmode_ff <= `LSR_VAR_SMOOTH;
        dx_ff    <= 17'h00000;
        dy_ff    <= 17'h00000;
        {xmaj_ff, sm_neg_ff, sn_neg_ff} <= 3'h0;
        {m_ff, n_ff, left_ff, dn_ff, dm_ff} <= 60'h0;
        err_ff   <= 15'h0000;
        bidx_ff  <= 4'h0;
        rep_ff   <= 9'h000;
        sel_ff   <= SEL_T;
        rem_ff   <= 52'h0;
        dsh_ff   <= 52'h0;
        q_ff     <= 16'h0000;
        cnt_ff   <= 5'h00;
        run_ff   <= 4'h0;
        fx_ff    <= 12'h000;
        fy_ff    <= 12'h000;
        {ft_ff, fz_ff, fc_ff, fv_ff} <= 64'h0;
    end else begin
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    {xa_ff, ya_ff, za_ff, zb_ff} <=
                        {seg_xa, seg_ya, seg_za, seg_zb};
                    {ca_ff, cb_ff, iwa_ff, iwb_ff} <=
                        {seg_ca, seg_cb, seg_iwa, seg_iwb};
                    {va_ff, vb_ff, vprov_ff} <= {seg_va, seg_vb, seg_vprov};
                    vmode_ff  <= seg_vmode;
                    dx_ff     <= sdx;
                    dy_ff     <= sdy;
                    xmaj_ff   <= sxmaj;
                    sm_neg_ff <= smn;
                    sn_neg_ff <= snn;
                    m_ff      <= ms;
                    n_ff      <= ns;
                    left_ff   <= sdm;                             // [R4]
                    dm_ff     <= sdm;
                    dn_ff     <= sdn;
                    err_ff    <= serr;
                    // Clipped segments simply keep the running count [R19]
                    if (seg_group_start || seg_independent) begin
                        bidx_ff <= 4'h0;                          // [R18]
                        rep_ff  <= 9'h000;
                    end
                    state_ff <= ST_POS;
                end
            end
            ST_POS: begin
                // Skipping masked positions saves the divider cycles
                if (left_ff == 12'h000)
                    state_ff <= ST_IDLE;                          // [R6]
                else if (dash_on) begin                           // [R22]
                    sel_ff   <= SEL_T;
                    state_ff <= ST_DLOAD;
                end else
                    state_ff <= ST_STEP;
            end
            ST_DLOAD: begin
                rem_ff   <= ld_n;
                dsh_ff   <= ld_d << 15;
                q_ff     <= 16'h0000;
                cnt_ff   <= `LSR_DIV_STEPS;
                state_ff <= ST_DIV;
            end
            ST_DIV: begin
                if (rem_ge)
                    rem_ff <= rem_ff - dsh_ff;
                dsh_ff <= dsh_ff >> 1;
                q_ff   <= nxt_q;
                cnt_ff <= cnt_ff - 5'h01;
                if (cnt_ff == 5'h01) begin
                    if (sel_ff == SEL_T) begin
                        ft_ff    <= nxt_q;                        // [R9]
                        sel_ff   <= SEL_C;
                        state_ff <= ST_DLOAD;
                    end else if (sel_ff == SEL_C) begin
                        fc_ff  <= nxt_q;                          // [R10]
                        sel_ff <= SEL_V;
                        state_ff <= (vmode_ff == `LSR_VAR_SMOOTH) ?
                                    ST_DLOAD : ST_EMIT;
                    end else begin
                        fv_ff    <= nxt_q;                        // [R12]
                        state_ff <= ST_EMIT;
                    end
                end
                if (cnt_ff == 5'h01 && sel_ff != SEL_T &&
                    (sel_ff == SEL_V || vmode_ff != `LSR_VAR_SMOOTH)) begin
                    fx_ff  <= xmaj_ff ? m_ff : nlow;              // [R21]
                    fy_ff  <= xmaj_ff ? nlow : m_ff;
                    run_ff <= 4'h0;
                end
            end
            ST_EMIT: begin
                fz_ff <= zlin[31:16];
                fv_ff <= vsel;
                // Output fields stay put until taken [R24]
                if (frag_ready && frag_valid) begin
                    if (run_last)
                        state_ff <= ST_STEP;
                    else begin
                        run_ff <= run_ff + 4'h1;                  // [R21]
                        if (xmaj_ff)
                            fy_ff <= fy_ff + 12'h001;
                        else
                            fx_ff <= fx_ff + 12'h001;
                    end
                end
            end
            ST_STEP: begin
                m_ff    <= sm_neg_ff ? m_ff - 12'h001 : m_ff + 12'h001; // [R7]
                if (err_ff > 0)                                   // [R5]
                    n_ff <= sn_neg_ff ? n_ff - 12'h001 : n_ff + 12'h001;
                err_ff  <= nxt_err;                               // [R8]
                left_ff <= left_ff - 12'h001;                     // [R2]
                if (rep_ff + 9'h001 >= factor_ff) begin           // [R16]
                    rep_ff  <= 9'h000;
                    bidx_ff <= bidx_ff + 4'h1;
                end else
                    rep_ff <= rep_ff + 9'h001;                    // [R17]
                state_ff <= ST_POS;
            end
            default: state_ff <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
// Depth and linear varyings settle one cycle into the emit state
reg emit_rdy_ff;
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
        emit_rdy_ff <= 1'b0;
    else
        emit_rdy_ff <= (state_ff == ST_EMIT);
end

assign seg_ready  = (state_ff == ST_IDLE);
assign frag_valid = (state_ff == ST_EMIT) && emit_rdy_ff;         // [R24]
assign frag_x     = fx_ff;
assign frag_y     = fy_ff;
assign frag_t     = ft_ff;
assign frag_z     = fz_ff;
assign frag_c     = fc_ff;
assign frag_v     = fv_ff;
assign aa_en      = aa_ff;
assign line_width = width_ff;

endmodule // lsr_line_raster

// ==== verification/lsr_chk.sv ====
`timescale 1ns/10ps
module lsr_chk (
    input wire        ref_clk,
    input wire        resetn,
    input wire        cfg_wr,
    input wire        cfg_aa_en,
    input wire [7:0]  cfg_width,
    input wire        aa_en,
    input wire [3:0]  line_width,
    input wire        seg_valid,
    input wire        seg_ready,
    input wire        frag_valid,
    input wire        frag_ready,
    input wire [11:0] frag_x,
    input wire [11:0] frag_y,
    input wire [15:0] frag_z,
    input wire [15:0] frag_v
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // --------
    // Handshakes
    // --------
    property p_hold;
        frag_valid && !frag_ready |=> frag_valid &&
            $stable({frag_x, frag_y, frag_z, frag_v});
    endproperty
    a_hold: assert property (p_hold) else $error("fragment moved");
    property p_busy;
        frag_valid |-> !seg_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready in emit");
    property p_take;
        seg_valid && seg_ready |=> !seg_ready ##0 (!frag_valid [*8]);
    endproperty
    a_take: assert property (p_take) else $error("bad take");
    // Masked runs emit nothing, so the bound is wide
    property p_progress;
        !seg_ready && !frag_valid |-> ##[1:1000] (frag_valid || seg_ready);
    endproperty
    a_progress: assert property (p_progress) else $error("stuck");
    // --------
    // Width and flags
    // --------
    property p_w_low;
        cfg_wr && cfg_width < 8'h18 |=> line_width == 4'h1;
    endproperty
    a_w_low: assert property (p_w_low) else $error("width not one");
    property p_w_high;
        cfg_wr && cfg_width > 8'h77 |=> line_width == 4'h8;
    endproperty
    a_w_high: assert property (p_w_high) else $error("no clamp");
    property p_w_mid;
        cfg_wr && cfg_width >= 8'h18 && cfg_width < 8'h78 |=>
            line_width == (($past(cfg_width) + 9'h008) >> 4);
    endproperty
    a_w_mid: assert property (p_w_mid) else $error("bad rounding");
    property p_w_hold;
        !cfg_wr |=> $stable(line_width) && $stable(aa_en);
    endproperty
    a_w_hold: assert property (p_w_hold) else $error("config moved");
    property p_aa;
        cfg_wr |=> aa_en == $past(cfg_aa_en);
    endproperty
    a_aa: assert property (p_aa) else $error("aa bit not stored");
    c_stall: cover property (frag_valid && !frag_ready);
    c_take: cover property (seg_valid && seg_ready);
    c_clamp: cover property (cfg_wr && cfg_width > 8'h77);
endmodule // lsr_chk

bind lsr_line_raster lsr_chk u_chk (.*);

// ==== verification/lsr_line_raster_tb_top.sv ====
`timescale 1ns/10ps
`include "lsr_defs.vh"
`define CHK(n, e, g) chk(n, (e) === (g), e, g)
module lsr_line_raster_tb_top;
    reg         ref_clk = 1'b0;
    reg         resetn = 1'b0;
    reg         set_dash_pattern = 1'b0;
    reg  [15:0] dash_factor_in = 16'h0001;
    reg  [31:0] dash_pattern_in = 32'h0000FFFF;
    reg         cfg_wr = 1'b0;
    reg         cfg_dash_en = 1'b0;
    reg         cfg_aa_en = 1'b0;
    reg  [7:0]  cfg_width = 8'h10;
    reg         seg_valid = 1'b0;
    reg  [15:0] seg_xa = 16'h0000, seg_ya = 16'h0000;
    reg  [15:0] seg_xb = 16'h0000, seg_yb = 16'h0000;
    reg  [15:0] seg_za = 16'h1234, seg_zb = 16'h5678;
    reg  [15:0] seg_ca = 16'h4000, seg_cb = 16'h2000;
    reg  [15:0] seg_iwa = 16'h1000, seg_iwb = 16'h0800;
    reg  [15:0] seg_va = 16'h1111, seg_vb = 16'h2222;
    reg  [15:0] seg_vprov = 16'hBEEF;
    reg  [1:0]  seg_vmode = `LSR_VAR_FLAT;
    reg         seg_group_start = 1'b0;
    reg         seg_independent = 1'b0;
    reg         slow = 1'b1;
    wire        aa_en, seg_ready, frag_valid, frag_ready;
    wire [3:0]  line_width;
    wire [11:0] frag_x, frag_y;
    wire [15:0] frag_t, frag_z, frag_c, frag_v;
    integer     fails = 0;
    integer     compares = 0;
    reg  [7:0]  base, b0, cnt, i, k, p, m;
    lsr_line_raster DUT (.*);
    lsr_sink sink (.*);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // --------
    // Shared tasks
    // --------
    task chk(input string n, input ok, input [31:0] e, g);
        begin
            compares = compares + 1;
            if (ok !== 1'b1) begin
                fails = fails + 1;
                $display("[ERR] %s expected %0h seen %0h", n, e, g);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("compares=%0d fails=%0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task set_cfg(input [7:0] w, input aa, en);
        begin
            @(negedge ref_clk);
            cfg_width = w;
            cfg_aa_en = aa;
            cfg_dash_en = en;
            cfg_wr = 1'b1;
            @(negedge ref_clk);
            cfg_wr = 1'b0;
        end
    endtask
    task set_dash(input [15:0] f, input [31:0] pat);
        begin
            @(negedge ref_clk);
            dash_factor_in = f;
            dash_pattern_in = pat;
            set_dash_pattern = 1'b1;
            @(negedge ref_clk);
            set_dash_pattern = 1'b0;
        end
    endtask
    task run_seg(input [15:0] xa, ya, xb, yb, input g, ind);
        integer w;
        begin
            @(negedge ref_clk);
            seg_xa = xa;
            seg_ya = ya;
            seg_xb = xb;
            seg_yb = yb;
            seg_group_start = g;
            seg_independent = ind;
            base = sink.n;
            seg_valid = 1'b1;
            @(negedge ref_clk);
            seg_valid = 1'b0;
            w = 0;
            while (seg_ready !== 1'b1 && w < 4000) begin
                @(negedge ref_clk);
                w = w + 1;
            end
            `CHK("seg_done", 1'b1, w < 4000);
            cnt = sink.n - base;
        end
    endtask
    // --------
    // Scenarios
    // --------
    task t_reset;
        begin
            `CHK("width", 4'h1, line_width);
            `CHK("aa", 1'b0, aa_en);
            `CHK("seg_ready", 1'b1, seg_ready);
            `CHK("frag_valid", 1'b0, frag_valid);
        end
    endtask
    task t_width;
        begin
            for (i = 8'h00; i < 8'hF0; i = i + 8'h17) begin
                set_cfg(i, i[0], 1'b0);
                m = (i + 8'h08) >> 4;
                m = (m == 8'h00) ? 8'h01 : (m > 8'h08) ? 8'h08 : m;
                `CHK("width", m[3:0], line_width);
                `CHK("aa", i[0], aa_en);
            end
            set_cfg(8'h10, 1'b0, 1'b0);
        end
    endtask
    task t_axis;
        begin
            run_seg(16'h0018, 16'h0018, 16'h0058, 16'h0018, 1'b1, 1'b0);
            `CHK("h_cnt", 8'h04, cnt);
            `CHK("t0", 16'h0000, sink.ts[base]);
            `CHK("z0", 1'b1, sink.zs[base] >= 16'h1233);
            for (k = 8'h00; k < cnt; k = k + 8'h01) begin
                p = base + k;
                `CHK("h_x", 12'h001 + k, sink.xs[p]);
                `CHK("h_y", 12'h001, sink.ys[p]);
                `CHK("flat", 16'hBEEF, sink.vs[p]);
                if (k > 0)
                    `CHK("t_up", 1'b1, sink.ts[p] > sink.ts[p - 1]);
            end
            `CHK("c_persp", 1'b1, frag_c - 16'h2CCB < 16'h0003);
            `CHK("z_lin", 1'b1, frag_z - 16'h4566 < 16'h0003);
            seg_vmode = `LSR_VAR_NOPERSP;
            run_seg(16'h0018, 16'h0018, 16'h0018, 16'h0048, 1'b1, 1'b0);
            `CHK("v_cnt", 8'h03, cnt);
            for (k = 8'h00; k < cnt; k = k + 8'h01) begin
                p = base + k;
                `CHK("v_y", 12'h001 + k, sink.ys[p]);
                `CHK("v_x", 12'h001, sink.xs[p]);
            end
            `CHK("v_lin", 1'b1, frag_v - 16'h1C70 < 16'h0003);
            seg_vmode = `LSR_VAR_SMOOTH;
            run_seg(16'h0018, 16'h0018, 16'h0038, 16'h0028, 1'b1, 1'b0);
            b0 = base;
            run_seg(16'h0038, 16'h0028, 16'h0058, 16'h0038, 1'b0, 1'b0);
            `CHK("j_cnt", 8'h04, sink.n - b0);
            for (k = 8'h00; k < 8'h04; k = k + 8'h01) begin
                p = b0 + k;
                `CHK("j_x", 12'h001 + k, sink.xs[p]);
            end
            `CHK("v_persp", 1'b1, frag_v - 16'h1554 < 16'h0003);
        end
    endtask
    task dash_case(input en, ld, input [15:0] f, input [31:0] pat,
                   input g, ind, input [7:0] e);
        begin
            set_cfg(8'h10, 1'b0, en);
            if (ld)
                set_dash(f, pat);
            run_seg(16'h0008, 16'h0018, 16'h0088, 16'h0018, g, ind);
            m = 8'h00;
            for (k = 8'h00; k < cnt; k = k + 8'h01) begin
                p = base + k;
                m = m | (8'h01 << sink.xs[p]);
            end
            `CHK("dash_mask", e, m);
            `CHK("dash_cnt", $countones(e), cnt);
        end
    endtask
    task t_dash;
        begin
            dash_case(1, 0, 16'h0001, 32'h0, 1, 0, 8'hFF);
            dash_case(1, 1, 16'h0001, 32'h5555, 1, 0, 8'h55);
            dash_case(1, 1, 16'h0000, 32'h5555, 1, 0, 8'h55);
            dash_case(1, 1, 16'h0002, 32'h5555, 1, 0, 8'h33);
            dash_case(1, 1, 16'h012C, 32'h0001, 1, 0, 8'hFF);
            dash_case(1, 1, 16'hFFFB, 32'h0001, 1, 0, 8'h01);
            dash_case(1, 1, 16'h0001, 32'hFFFF0000, 1, 0, 8'h00);
            dash_case(1, 1, 16'h0003, 32'h0003, 1, 0, 8'h3F);
            dash_case(0, 1, 16'h0001, 32'h0000, 1, 0, 8'hFF);
            dash_case(1, 1, 16'h0001, 32'h00FF, 1, 0, 8'hFF);
            dash_case(1, 0, 16'h0001, 32'h0, 0, 0, 8'h00);
            dash_case(1, 0, 16'h0001, 32'h0, 0, 1, 8'hFF);
        end
    endtask
    task t_wide;
        begin
            set_cfg(8'h30, 1'b0, 1'b0);
            run_seg(16'h0018, 16'h0018, 16'h0048, 16'h0048, 1'b1, 1'b0);
            `CHK("w_cnt", 8'h09, cnt);
            for (k = 8'h00; k < 8'h09; k = k + 8'h01) begin
                p = base + k;
                `CHK("w_x", 12'h001 + k / 3, sink.xs[p]);
                `CHK("w_y", 12'h000 + k / 3 + k % 3, sink.ys[p]);
            end
            set_cfg(8'h30, 1'b0, 1'b1);
            set_dash(16'h0001, 32'h0001);
            run_seg(16'h0018, 16'h0018, 16'h0048, 16'h0048, 1'b1, 1'b0);
            `CHK("wd_cnt", 8'h03, cnt);
            set_cfg(8'h10, 1'b0, 1'b0);
        end
    endtask
    // --------
    // Sequence and watchdog
    // --------
    initial begin
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        t_reset;
        t_width;
        t_axis;
        slow = 1'b0;
        t_dash;
        slow = 1'b1;
        t_wide;
        wrap_up;
    end
    initial begin
        #100000;
        fails = fails + 1;
        wrap_up;
    end
endmodule // lsr_line_raster_tb_top

// ==== verification/lsr_sink.sv ====
`timescale 1ns/10ps
module lsr_sink (
    input  wire        ref_clk,
    input  wire        slow,
    input  wire        frag_valid,
    output reg         frag_ready,
    input  wire [11:0] frag_x,
    input  wire [11:0] frag_y,
    input  wire [15:0] frag_t,
    input  wire [15:0] frag_z,
    input  wire [15:0] frag_v
);
    reg [11:0] xs [0:255];
    reg [11:0] ys [0:255];
    reg [15:0] ts [0:255];
    reg [15:0] zs [0:255];
    reg [15:0] vs [0:255];
    reg [7:0]  n  = 8'h00;
    reg [1:0]  ph = 2'h0;
    initial frag_ready = 1'b0;
    // --------
    // Take and log
    // --------
    always @(posedge ref_clk) begin
        if (frag_valid && frag_ready) begin
            xs[n] <= frag_x;
            ys[n] <= frag_y;
            ts[n] <= frag_t;
            zs[n] <= frag_z;
            vs[n] <= frag_v;
            n <= n + 8'h01;
        end
    end
    // Ready ignores valid, so stalls land mid-fragment too
    always @(negedge ref_clk) begin
        ph = (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        frag_ready = !slow || (ph == 2'h0);
    end
endmodule // lsr_sink
